// ==== gpsc_partner.sv ====
// Behavioural remote link partner that emits fault, idle error and attempt fail pulses.
`timescale 1ns/1ps

module gpsc_partner (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic [1:0] kind,
  input  wire logic [8:0] count,
  output logic            busy,
  output logic            ms_fault_event,
  output logic            idle_error_event,
  output logic            gig_attempt_fail
);
  logic [8:0] left_q;

  // Counts down one pulse per cycle; back to back pulses stress the counters.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_q <= 9'h000;
    end else if (start) begin
      left_q <= count;
    end else if (left_q != 9'h000) begin
      left_q <= left_q - 9'h001;
    end
  end

  // Only the selected kind pulses, so the other event lines stay quiet.
  assign busy             = start | (left_q != 9'h000);
  assign ms_fault_event   = (left_q != 9'h000) && (kind == 2'h0);
  assign idle_error_event = (left_q != 9'h000) && (kind == 2'h1);
  assign gig_attempt_fail = (left_q != 9'h000) && (kind == 2'h2);
endmodule

// ==== gpsc_pkg.sv ====
// Shared constants and types for the gigabit copper PHY status and control register bank.
package gpsc_pkg;

  // ----------------------------------------------------------------
  // Register indices and APB address width
  // ----------------------------------------------------------------
  localparam logic [7:0]  GPSC_IDX_STAT     = 8'h0a;
  localparam logic [7:0]  GPSC_IDX_EXT      = 8'h0f;
  localparam logic [7:0]  GPSC_IDX_CTRL     = 8'h10;
  localparam logic [7:0]  GPSC_IDX_IRQ_ST   = 8'h18;
  localparam logic [7:0]  GPSC_IDX_IRQ_MSK  = 8'h19;
  localparam logic [7:0]  GPSC_IDX_SWRST    = 8'h1a;
  localparam int          GPSC_ADDR_W       = 10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GPSC_ST_FAULT   = 15;
  localparam int GPSC_ST_MASTER  = 14;
  localparam int GPSC_ST_LRX     = 13;
  localparam int GPSC_ST_RRX     = 12;
  localparam int GPSC_ST_LP_FD   = 11;
  localparam int GPSC_ST_LP_HD   = 10;
  localparam int GPSC_IDLE_W     = 8;
  localparam int GPSC_CT_LP_DIS  = 15;
  localparam int GPSC_CT_DS_HI   = 14;
  localparam int GPSC_CT_DS_LO   = 12;
  localparam int GPSC_CT_DS_EN   = 11;
  localparam int GPSC_CT_FORCE   = 10;
  localparam int GPSC_CT_ED_HI   = 9;
  localparam int GPSC_CT_ED_LO   = 8;
  localparam int GPSC_CT_EXTD    = 7;
  localparam int GPSC_IRQ_N      = 3;
  localparam int GPSC_IRQ_FAULT  = 0;
  localparam int GPSC_IRQ_IDLE   = 1;
  localparam int GPSC_IRQ_DSHIFT = 2;
  localparam int GPSC_SWRST_BIT  = 0;

  // ----------------------------------------------------------------
  // Constant and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] GPSC_EXT_VALUE    = 16'h3000;
  localparam logic [2:0]  GPSC_DS_CNT_RST   = 3'h3;
  localparam logic        GPSC_DS_EN_RST    = 1'h0;
  localparam logic        GPSC_LP_DIS_RST   = 1'h0;
  localparam logic        GPSC_FORCE_RST    = 1'h0;
  localparam logic        GPSC_EXTD_RST     = 1'h0;
  localparam logic [2:0]  GPSC_IRQ_MSK_RST  = 3'h0;

  // Decoded register selection.
  typedef enum logic [2:0] {
    GPSC_R_NONE    = 3'b000,
    GPSC_R_STAT    = 3'b001,
    GPSC_R_EXT     = 3'b010,
    GPSC_R_CTRL    = 3'b011,
    GPSC_R_IRQ_ST  = 3'b100,
    GPSC_R_IRQ_MSK = 3'b101,
    GPSC_R_SWRST   = 3'b110
  } gpsc_reg_t;

endpackage

// ==== gpsc_regs.sv ====
// APB register bank for gigabit copper PHY link status and copper line control.
`timescale 1ns/1ps

module gpsc_regs
  import gpsc_pkg::*;
#(
  parameter int IDLE_W = GPSC_IDLE_W
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [GPSC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   ms_fault_event,
  input  wire logic                   ms_resolved_master,
  input  wire logic                   local_rx_ok,
  input  wire logic                   remote_rx_ok,
  input  wire logic                   lp_gig_full_cap,
  input  wire logic                   lp_gig_half_cap,
  input  wire logic                   idle_error_event,
  input  wire logic                   gig_attempt_fail,
  input  wire logic                   link_state_up,
  input  wire logic                   speed_is_gig,
  input  wire logic [1:0]             energy_sense_default_input,
  output logic                        link_pulse_disable,
  output logic                        downshift_req,
  output logic                        link_up,
  output logic                        energy_sense_on,
  output logic                        energy_nlp_tx,
  output logic                        rx_threshold_low,
  output logic                        irq
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (IDLE_W != GPSC_IDLE_W) begin : g_bad_idle
    $error("idle error count must fill status bits 7:0");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                 fault_q;
  logic [IDLE_W-1:0]    idle_q;
  logic                 lp_dis_q;
  logic [2:0]           ds_cnt_q;
  logic                 ds_en_q;
  logic [2:0]           ds_cnt_eff_q;
  logic                 ds_en_eff_q;
  logic                 force_q;
  logic [1:0]           edet_q;
  logic                 extd_q;
  logic                 init_done_q;
  logic                 sw_reset_q;
  logic [2:0]           attempt_q;
  logic                 downshift_q;
  logic [GPSC_IRQ_N-1:0] irq_st_q;
  logic [GPSC_IRQ_N-1:0] irq_msk_q;
  logic [GPSC_IRQ_N-1:0] irq_ev;
  logic [31:0]          prdata_q;
  logic [31:0]          rd_value;
  logic [15:0]          stat_value;
  logic [15:0]          ctrl_value;
  logic                 apb_setup;
  logic                 apb_wr;
  logic                 rd_setup;
  logic                 stat_rd;
  logic                 ds_fire;
  gpsc_reg_t            sel;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Word index is the byte address divided by four; low two bits are ignored.
  function automatic gpsc_reg_t decode(input logic [GPSC_ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[GPSC_ADDR_W-1:2];
    if (idx == GPSC_IDX_STAT) begin
      return GPSC_R_STAT;
    end else if (idx == GPSC_IDX_EXT) begin
      return GPSC_R_EXT;
    end else if (idx == GPSC_IDX_CTRL) begin
      return GPSC_R_CTRL;
    end else if (idx == GPSC_IDX_IRQ_ST) begin
      return GPSC_R_IRQ_ST;
    end else if (idx == GPSC_IDX_IRQ_MSK) begin
      return GPSC_R_IRQ_MSK;
    end else if (idx == GPSC_IDX_SWRST) begin
      return GPSC_R_SWRST;
    end
    return GPSC_R_NONE;
  endfunction

  // The slave never inserts wait states; unmapped words answer with an error.
  assign sel       = decode(paddr);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && (sel == GPSC_R_NONE);
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite && (sel != GPSC_R_NONE);
  assign rd_setup  = apb_setup && !pwrite;
  assign stat_rd   = rd_setup && (sel == GPSC_R_STAT);
  assign prdata    = prdata_q;

  // ----------------------------------------------------------------
  // Link status register
  // ----------------------------------------------------------------
  // The read snapshot and the clear share one edge, so an event on that
  // edge survives into the next reading instead of being dropped.
  // A software reset loses to an event in the same cycle, as the counter does.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else if (ms_fault_event) begin
      fault_q <= 1'b1;
    end else if (sw_reset_q || stat_rd) begin
      fault_q <= 1'b0;
    end
  end

  gpsc_sat_counter #(
    .W       (IDLE_W)
  ) u_idle_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (stat_rd || sw_reset_q),
    .inc     (idle_error_event),
    .count_q (idle_q)
  );

  // Reserved bits 9:8 read zero.
  always_comb begin
    stat_value                 = '0;
    stat_value[GPSC_ST_FAULT]  = fault_q;
    stat_value[GPSC_ST_MASTER] = ms_resolved_master;
    stat_value[GPSC_ST_LRX]    = local_rx_ok;
    stat_value[GPSC_ST_RRX]    = remote_rx_ok;
    stat_value[GPSC_ST_LP_FD]  = lp_gig_full_cap;
    stat_value[GPSC_ST_LP_HD]  = lp_gig_half_cap;
    stat_value[IDLE_W-1:0]     = idle_q;
  end

  // ----------------------------------------------------------------
  // Copper line control register
  // ----------------------------------------------------------------
  // Fields that are cleared by both resets.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_dis_q <= GPSC_LP_DIS_RST;
    end else if (sw_reset_q) begin
      lp_dis_q <= GPSC_LP_DIS_RST;
    end else if (apb_wr && sel == GPSC_R_CTRL) begin
      lp_dis_q <= pwdata[GPSC_CT_LP_DIS];
    end
  end

  // Fields that keep their value across a software reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ds_cnt_q <= GPSC_DS_CNT_RST;
      ds_en_q  <= GPSC_DS_EN_RST;
      force_q  <= GPSC_FORCE_RST;
      extd_q   <= GPSC_EXTD_RST;
    end else if (apb_wr && sel == GPSC_R_CTRL) begin
      ds_cnt_q <= pwdata[GPSC_CT_DS_HI:GPSC_CT_DS_LO];
      ds_en_q  <= pwdata[GPSC_CT_DS_EN];
      force_q  <= pwdata[GPSC_CT_FORCE];
      extd_q   <= pwdata[GPSC_CT_EXTD];
    end
  end

  // The strap level cannot be taken under the asynchronous reset, so it is
  // loaded on the first clock after release instead.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_done_q <= 1'b0;
      edet_q      <= 2'h0;
    end else if (!init_done_q) begin
      init_done_q <= 1'b1;
      edet_q      <= energy_sense_default_input;
    end else if (apb_wr && sel == GPSC_R_CTRL) begin
      edet_q      <= pwdata[GPSC_CT_ED_HI:GPSC_CT_ED_LO];
    end
  end

  // Working copies of the downshift fields; a change mid-link would be
  // disruptive, so they follow the register only on a software reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ds_cnt_eff_q <= GPSC_DS_CNT_RST;
      ds_en_eff_q  <= GPSC_DS_EN_RST;
    end else if (sw_reset_q) begin
      ds_cnt_eff_q <= ds_cnt_q;
      ds_en_eff_q  <= ds_en_q;
    end
  end

  always_comb begin
    ctrl_value                                = '0;
    ctrl_value[GPSC_CT_LP_DIS]                = lp_dis_q;
    ctrl_value[GPSC_CT_DS_HI:GPSC_CT_DS_LO]   = ds_cnt_q;
    ctrl_value[GPSC_CT_DS_EN]                 = ds_en_q;
    ctrl_value[GPSC_CT_FORCE]                 = force_q;
    ctrl_value[GPSC_CT_ED_HI:GPSC_CT_ED_LO]   = edet_q;
    ctrl_value[GPSC_CT_EXTD]                  = extd_q;
  end

  // ----------------------------------------------------------------
  // Software reset strobe
  // ----------------------------------------------------------------
  // Writing a one gives a single-cycle reset pulse to the register fields.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_reset_q <= 1'b0;
    end else begin
      sw_reset_q <= apb_wr && (sel == GPSC_R_SWRST) && pwdata[GPSC_SWRST_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Downshift attempt tracking
  // ----------------------------------------------------------------
  // A request stands until link comes up or software resets the block.
  assign ds_fire = gig_attempt_fail && ds_en_eff_q && (attempt_q == ds_cnt_eff_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attempt_q   <= 3'h0;
      downshift_q <= 1'b0;
    end else if (sw_reset_q || link_state_up) begin
      attempt_q   <= 3'h0;
      downshift_q <= 1'b0;
    end else if (gig_attempt_fail && !downshift_q) begin
      attempt_q   <= ds_fire ? 3'h0 : attempt_q + 3'h1;
      downshift_q <= ds_fire;
    end
  end

  // ----------------------------------------------------------------
  // Line behaviour outputs
  // ----------------------------------------------------------------
  assign link_pulse_disable = lp_dis_q;
  assign downshift_req      = downshift_q;
  assign link_up            = link_state_up || (force_q && !speed_is_gig);
  assign energy_sense_on    = edet_q[1];
  assign energy_nlp_tx      = edet_q[1] && edet_q[0];
  assign rx_threshold_low   = extd_q;

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  assign irq_ev = {ds_fire && !downshift_q, idle_error_event, ms_fault_event};

  // Write one to clear; a new event in the same cycle wins over the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q <= '0;
    end else if (apb_wr && sel == GPSC_R_IRQ_ST) begin
      irq_st_q <= (irq_st_q & ~pwdata[GPSC_IRQ_N-1:0]) | irq_ev;
    end else begin
      irq_st_q <= irq_st_q | irq_ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_msk_q <= GPSC_IRQ_MSK_RST;
    end else if (apb_wr && sel == GPSC_R_IRQ_MSK) begin
      irq_msk_q <= pwdata[GPSC_IRQ_N-1:0];
    end
  end

  assign irq = |(irq_st_q & irq_msk_q);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Status and extended status accept no writes at all.
  always_comb begin
    rd_value = '0;
    unique case (sel)
      GPSC_R_STAT:    rd_value[15:0] = stat_value;
      GPSC_R_EXT:     rd_value[15:0] = GPSC_EXT_VALUE;
      GPSC_R_CTRL:    rd_value[15:0] = ctrl_value;
      GPSC_R_IRQ_ST:  rd_value[GPSC_IRQ_N-1:0] = irq_st_q;
      GPSC_R_IRQ_MSK: rd_value[GPSC_IRQ_N-1:0] = irq_msk_q;
      GPSC_R_SWRST:   rd_value = '0;
      GPSC_R_NONE:    rd_value = '0;
    endcase
  end

  // Sampled in the setup phase and held through the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (rd_setup) begin
      prdata_q <= rd_value;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence stat_rd_s;
    stat_rd && !ms_fault_event && !idle_error_event;
  endsequence

  sequence access_s;
    psel && penable && pready;
  endsequence

  fault_set_a: assert property (ms_fault_event |=> fault_q)
    else $error("fault flag not set by event");
  fault_clear_a: assert property (stat_rd_s |=> (!fault_q) and access_s)
    else $error("fault flag not cleared by status read");
  idle_clear_a: assert property (stat_rd_s |=> (idle_q == '0) and access_s)
    else $error("idle count not cleared by status read");
  idle_sat_a: assert property ((&idle_q) && !stat_rd && !sw_reset_q |=> &idle_q)
    else $error("idle count wrapped");
  read_return_a: assert property (stat_rd |=> prdata[7:0] == $past(idle_q)
                                   && prdata[15] == $past(fault_q))
    else $error("status read lost value");
  status_map_a: assert property (stat_rd |=> prdata[14:10] == $past(stat_value[14:10])
                                 && prdata[9:8] == 2'h0)
    else $error("status bits misplaced");
  ext_value_a: assert property (rd_setup && sel == GPSC_R_EXT |=> prdata == 32'h0000_3000)
    else $error("extended status wrong");
  lp_reset_a: assert property (sw_reset_q |=> !link_pulse_disable)
    else $error("link pulse disable survived reset");
  ds_hold_a: assert property (!sw_reset_q |=> $stable(ds_cnt_eff_q) && $stable(ds_en_eff_q))
    else $error("downshift fields changed without reset");
  ds_gate_a: assert property (!ds_en_eff_q && !downshift_q |=> !downshift_q)
    else $error("downshift without enable");
  force_link_a: assert property (force_q && !speed_is_gig |-> link_up)
    else $error("forced link not up");
  energy_a: assert property (energy_nlp_tx |-> energy_sense_on && edet_q == 2'h3)
    else $error("energy detect decode wrong");

endmodule

// ==== gpsc_sat_counter.sv ====
// Saturating event counter with clear-on-read, used for the idle error count.
`timescale 1ns/1ps

module gpsc_sat_counter
  import gpsc_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clear,
  input  wire logic         inc,
  output logic [W-1:0]      count_q
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (W < 1 || W > 16) begin : g_bad_width
    $error("gpsc_sat_counter width out of range");
  end

  logic sat;

  assign sat = &count_q;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // An event in the clearing cycle is kept as the first count of the next period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (clear) begin
      count_q <= inc ? W'(1) : '0;
    end else if (inc && !sat) begin
      count_q <= count_q + W'(1);
    end
  end

endmodule

// ==== test_gige_phy_status_copper_ctrl.sv ====
// Self-checking testbench for the copper PHY status and control register bank.
`timescale 1ns/1ps

module test_gige_phy_status_copper_ctrl import gpsc_pkg::*;;
  typedef struct {
    logic [9:0]  a;
    logic        w;
    logic [31:0] d;
    logic        err;
  } gpsc_row_t;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        role, lrx, rrx, fdc, hdc, lsu, gig, start, busy, err;
  logic        fault_ev, idle_ev, fail_ev, lpd, dsr, lup, eso, ent, rtl, irq;
  logic [1:0]  strap, kind;
  logic [8:0]  count;
  int          n_mismatch, n_tests, i;
  gpsc_row_t   rows [10];

  // ----------------------------------------------------------------
  // Design, partner and clock
  // ----------------------------------------------------------------
  gpsc_regs #(.IDLE_W(8)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ms_fault_event(fault_ev), .ms_resolved_master(role), .local_rx_ok(lrx),
    .remote_rx_ok(rrx), .lp_gig_full_cap(fdc), .lp_gig_half_cap(hdc),
    .idle_error_event(idle_ev), .gig_attempt_fail(fail_ev), .link_state_up(lsu),
    .speed_is_gig(gig), .energy_sense_default_input(strap), .link_pulse_disable(lpd),
    .downshift_req(dsr), .link_up(lup), .energy_sense_on(eso), .energy_nlp_tx(ent),
    .rx_threshold_low(rtl), .irq(irq)
  );

  gpsc_partner i_partner (
    .pclk(pclk), .presetn(presetn), .start(start), .kind(kind), .count(count),
    .busy(busy), .ms_fault_event(fault_ev), .idle_error_event(idle_ev),
    .gig_attempt_fail(fail_ev)
  );

  // Free running clock at 100 MHz.
  always #5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Prints the verdict and ends the run; the only place the run stops.
  task automatic close_out;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Case equality so that an unknown never passes for a match.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic [9:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      chk("pready", 32'h0, 32'h1);
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Asks the partner for n pulses of one kind and waits, bounded, until it is done.
  task automatic pulse(input logic [1:0] k, input logic [8:0] n);
    int t;
    @(posedge pclk);
    kind <= k;
    count <= n;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    for (t = 0; t < 600; t++) begin
      @(posedge pclk);
      #1;
      if (busy === 1'b0) break;
    end
    if (t == 600) begin
      chk("partner busy", 32'h1, 32'h0);
      close_out();
    end
  endtask

  // Lets the updates of the last edge land before outputs are looked at.
  task automatic settle;
    @(posedge pclk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, start, lsu, gig} = 8'h00;
    {role, lrx, rrx, fdc, hdc} = 5'b11010;
    paddr = 10'h000;
    pwdata = 32'h0;
    strap = 2'b11;
    kind = 2'h0;
    count = 9'h000;
    n_mismatch = 0;
    n_tests = 0;
    rows = '{'{10'h040, 1'b0, 32'h3300, 1'b0}, '{10'h03c, 1'b0, 32'h3000, 1'b0},
             '{10'h03c, 1'b1, 32'hffff, 1'b0}, '{10'h03c, 1'b0, 32'h3000, 1'b0},
             '{10'h028, 1'b0, 32'h6800, 1'b0}, '{10'h028, 1'b1, 32'hffff, 1'b0},
             '{10'h028, 1'b0, 32'h6800, 1'b0}, '{10'h064, 1'b0, 32'h0, 1'b0},
             '{10'h004, 1'b0, 32'h0, 1'b1}, '{10'h004, 1'b1, 32'h5, 1'b1}};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    for (i = 0; i < 10; i++) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w) begin
        chk("prdata", rd, rows[i].d);
      end
      chk("pslverr", {31'h0, err}, {31'h0, rows[i].err});
    end
    // Every level flipped, so a stuck status bit shows up.
    @(posedge pclk);
    {role, lrx, rrx, fdc, hdc} <= 5'b00101;
    apb(10'h028, 1'b0, 32'h0);
    chk("status levels", rd, 32'h1400);
    // Fault latches, clears on the read, then the interrupt is seen masked, unmasked and cleared.
    pulse(2'h0, 9'd1);
    apb(10'h028, 1'b0, 32'h0);
    chk("fault set", rd, 32'h9400);
    apb(10'h028, 1'b0, 32'h0);
    chk("fault cleared", rd, 32'h1400);
    apb(10'h060, 1'b0, 32'h0);
    chk("irq status", rd, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(10'h064, 1'b1, 32'h1);
    settle();
    chk("irq raised", {31'h0, irq}, 32'h1);
    apb(10'h060, 1'b1, 32'h1);
    settle();
    chk("irq cleared", {31'h0, irq}, 32'h0);
    // Idle errors beyond the counter's range saturate, then clear on read.
    pulse(2'h1, 9'd300);
    apb(10'h028, 1'b0, 32'h0);
    chk("idle saturated", rd, 32'h14ff);
    apb(10'h028, 1'b0, 32'h0);
    chk("idle cleared", rd, 32'h1400);
    // Each energy detect code, with pulse disable, forced link and long reach set.
    for (i = 0; i < 4; i++) begin
      apb(10'h040, 1'b1, 32'h8480 | (i << 8));
      settle();
      chk("sense on", {31'h0, eso}, {31'h0, i[1]});
      chk("nlp tx", {31'h0, ent}, {31'h0, i[1] & i[0]});
      chk("pulse disable", {31'h0, lpd}, 32'h1);
      chk("threshold", {31'h0, rtl}, 32'h1);
      chk("forced link", {31'h0, lup}, 32'h1);
    end
    @(posedge pclk);
    gig <= 1'b1;
    settle();
    chk("forced link gig", {31'h0, lup}, 32'h0);
    apb(10'h040, 1'b0, 32'h0);
    chk("ctrl readback", rd, 32'h8780);
    // Downshift settings wait for the software reset before they count.
    @(posedge pclk);
    gig <= 1'b0;
    apb(10'h040, 1'b1, 32'h9800);
    pulse(2'h2, 9'd2);
    chk("downshift early", {31'h0, dsr}, 32'h0);
    apb(10'h068, 1'b1, 32'h1);
    repeat (3) settle();
    chk("swrst pulse bit", {31'h0, lpd}, 32'h0);
    pulse(2'h2, 9'd1);
    chk("downshift one", {31'h0, dsr}, 32'h0);
    pulse(2'h2, 9'd1);
    chk("downshift two", {31'h0, dsr}, 32'h1);
    // Idle error and downshift events left their sticky status bits behind.
    apb(10'h060, 1'b0, 32'h0);
    chk("irq status events", rd, 32'h6);
    // A real link coming up raises the link and withdraws the downshift request.
    @(posedge pclk);
    lsu <= 1'b1;
    settle();
    chk("link state up", {31'h0, lup}, 32'h1);
    chk("downshift withdrawn", {31'h0, dsr}, 32'h0);
    @(posedge pclk);
    lsu <= 1'b0;
    // A second hardware reset reloads the energy bits from a new default.
    @(posedge pclk);
    presetn <= 1'b0;
    strap <= 2'b10;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(10'h040, 1'b0, 32'h0);
    chk("ctrl after reset", rd, 32'h3200);
    chk("downshift reset", {31'h0, dsr}, 32'h0);
    close_out();
  end
endmodule
